// >>> rtl/eirq_pkg.sv
// What this block does
// - Two-bit mode with polarity picks trigger; 00 off, 11 both edges.
// - Mode 01 detects low level, or high level when polarity is inverted.
// - Mode 10 detects falling edge, or rising edge when polarity is inverted.
// - Source flag sets whenever the selected trigger condition is met.
// - Flag and enable both one raise hold release and the channel request.
// - Channel 2 request targets vector 8018H.
// - Channel 3 request targets vector 801CH.
// - Channel 4 request targets vector 8020H.
// - Channel 5 request targets vector 8024H.
// - Channel 6 request targets vector 8034H.
// - Channel 7 request targets vector 8038H.
// - Odd channel uses bits 7:6 mode, bit 5 flag, bit 4 enable.
// - Even channel uses bits 3:2 mode, bit 1 flag, bit 0 enable.
// - One 8-bit read-write register per pair: 2/3, 4/5, 6/7.
// - Channel polarity comes from the port setting, pin passed straight or inverted.
// - Hold release moves standby to halt; accepted interrupt returns to run.
//
// Constants, types and shared decode for the external interrupt detector, channels 2 to 7.
// Assumes an 8-bit register port on the system clock.
package eirq_pkg;

  localparam int CH_N  = 6;
  localparam int REG_N = 3;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_PAIR_2_3   = 16'h7fd9;
  localparam logic [15:0] ADDR_PAIR_4_5   = 16'h7fda;
  localparam logic [15:0] ADDR_PAIR_6_7   = 16'h7fdb;
  localparam logic [15:0] ADDR_EVT_STATUS = 16'h7fdc;
  localparam logic [15:0] ADDR_EVT_MASK   = 16'h7fdd;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [5:0] EVT_RESET  = 6'h00;

  // ----------------------------------------------------------------
  // Field layout within a pair register
  // ----------------------------------------------------------------
  localparam int ODD_NIB_LSB  = 4;
  localparam int EVEN_NIB_LSB = 0;
  localparam int MODE_LSB     = 2;
  localparam int FLAG_BIT     = 1;
  localparam int EN_BIT       = 0;

  localparam logic [1:0] MODE_OFF   = 2'h0;
  localparam logic [1:0] MODE_LEVEL = 2'h1;
  localparam logic [1:0] MODE_EDGE  = 2'h2;
  localparam logic [1:0] MODE_BOTH  = 2'h3;

  // ----------------------------------------------------------------
  // Vector addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] VEC_CH2  = 16'h8018;
  localparam logic [15:0] VEC_CH3  = 16'h801c;
  localparam logic [15:0] VEC_CH4  = 16'h8020;
  localparam logic [15:0] VEC_CH5  = 16'h8024;
  localparam logic [15:0] VEC_CH6  = 16'h8034;
  localparam logic [15:0] VEC_CH7  = 16'h8038;
  localparam logic [15:0] VEC_NONE = 16'h0000;

  typedef enum logic [1:0] {PS_RUN, PS_STANDBY, PS_HALT} eirq_pstate_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } eirq_bus_req_type;

  typedef struct packed {
    logic [CH_N-1:0]             sync1;
    logic [CH_N-1:0]             sync2;
    logic [CH_N-1:0]             prev;
    logic [REG_N-1:0][7:0]       ctrl;
    logic [CH_N-1:0]             evt_status;
    logic [CH_N-1:0]             evt_mask;
    logic [7:0]                  rdata;
    logic [15:0]                 vector;
    eirq_pstate_type             pstate;
  } eirq_state_type;

  localparam eirq_state_type STATE_RESET = '{
    sync1      : 6'h00,
    sync2      : 6'h00,
    prev       : 6'h00,
    ctrl       : {REG_N{CTRL_RESET}},
    evt_status : EVT_RESET,
    evt_mask   : EVT_RESET,
    rdata      : 8'h00,
    vector     : VEC_NONE,
    pstate     : PS_RUN
  };

  // Channel index 0 is channel 2, so even index means even channel
  function automatic int eirq_ch_lsb(input int c);
    return (c % 2 == 1) ? ODD_NIB_LSB : EVEN_NIB_LSB;
  endfunction

  function automatic logic [15:0] eirq_vector(input int c);
    case (c)
      0:       return VEC_CH2;
      1:       return VEC_CH3;
      2:       return VEC_CH4;
      3:       return VEC_CH5;
      4:       return VEC_CH6;
      5:       return VEC_CH7;
      default: return VEC_NONE;
    endcase
  endfunction

endpackage

// >>> rtl/eirq_top.sv
// External interrupt detector for channels 2 to 7 with pair control registers.
// Assumes pins are asynchronous, polarity and CPU handshakes are on mclk.
`timescale 1ns/10ps
module eirq_top
  import eirq_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire eirq_bus_req_type bus,
  output logic [7:0]            rdata,
  input  wire logic [CH_N-1:0]  ext_irq_pin,
  input  wire logic [CH_N-1:0]  pin_invert,
  input  wire logic             standby_enter,
  input  wire logic             irq_accept,
  output logic [CH_N-1:0]       irq_request,
  output logic                  hold_release,
  output logic [15:0]           vector_addr,
  output logic                  vector_valid,
  output eirq_pstate_type       cpu_state,
  output logic                  irq
);

  eirq_state_type       st_q;
  eirq_state_type       st_d;
  logic [REG_N-1:0]     wr_sel;
  logic [REG_N-1:0]     rd_sel;
  logic [CH_N-1:0]      trig;

  // ----------------------------------------------------------------
  // Field access
  // ----------------------------------------------------------------
  function automatic logic [1:0] ch_mode(input logic [REG_N-1:0][7:0] r, input int c);
    return r[c/2][eirq_ch_lsb(c)+MODE_LSB +: 2];
  endfunction

  function automatic logic ch_flag(input logic [REG_N-1:0][7:0] r, input int c);
    return r[c/2][eirq_ch_lsb(c)+FLAG_BIT];
  endfunction

  function automatic logic ch_en(input logic [REG_N-1:0][7:0] r, input int c);
    return r[c/2][eirq_ch_lsb(c)+EN_BIT];
  endfunction

  function automatic logic [REG_N-1:0] ctrl_sel(input logic [15:0] a);
    logic [REG_N-1:0] s;
    s = '0;
    if (a == ADDR_PAIR_2_3) s[0] = 1'b1;
    if (a == ADDR_PAIR_4_5) s[1] = 1'b1;
    if (a == ADDR_PAIR_6_7) s[2] = 1'b1;
    return s;
  endfunction

  assign wr_sel = bus.wr ? ctrl_sel(bus.addr) : '0;
  assign rd_sel = bus.rd ? ctrl_sel(bus.addr) : '0;

  // ----------------------------------------------------------------
  // Trigger detection
  // ----------------------------------------------------------------
  always_comb begin
    logic eff;
    logic peff;
    eff  = 1'b0;
    peff = 1'b0;
    trig = '0;
    for (int c = 0; c < CH_N; c++) begin
      // Polarity applied to both samples, so a polarity change makes no edge
      eff  = st_q.sync2[c] ^ pin_invert[c];
      peff = st_q.prev[c] ^ pin_invert[c];
      unique case (ch_mode(st_q.ctrl, c))
        MODE_OFF:   trig[c] = 1'b0;
        MODE_LEVEL: trig[c] = ~eff;
        MODE_EDGE:  trig[c] = peff & ~eff;
        MODE_BOTH:  trig[c] = st_q.prev[c] ^ st_q.sync2[c];
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic found;
    found = 1'b0;
    st_d  = st_q;

    st_d.sync1 = ext_irq_pin;
    st_d.sync2 = st_q.sync1;
    st_d.prev  = st_q.sync2;
    st_d.rdata = 8'h00;

    // Register writes
    for (int i = 0; i < REG_N; i++) begin
      if (wr_sel[i]) begin
        st_d.ctrl[i] = bus.wdata;
      end
    end
    if (bus.wr && bus.addr == ADDR_EVT_MASK) begin
      st_d.evt_mask = bus.wdata[CH_N-1:0];
    end

    // Register reads, status clears on read
    if (bus.rd) begin
      for (int i = 0; i < REG_N; i++) begin
        if (rd_sel[i]) begin
          st_d.rdata = st_q.ctrl[i];
        end
      end
      if (bus.addr == ADDR_EVT_STATUS) begin
        st_d.rdata      = {2'h0, st_q.evt_status};
        st_d.evt_status = EVT_RESET;
      end
      if (bus.addr == ADDR_EVT_MASK) begin
        st_d.rdata = {2'h0, st_q.evt_mask};
      end
    end

    // Hardware set overrides any same-cycle clear
    for (int c = 0; c < CH_N; c++) begin
      if (trig[c]) begin
        st_d.ctrl[c/2][eirq_ch_lsb(c)+FLAG_BIT] = 1'b1;
        st_d.evt_status[c]                      = 1'b1;
      end
    end

    // Lowest pending channel wins the vector
    st_d.vector = VEC_NONE;
    for (int c = 0; c < CH_N; c++) begin
      if (!found && ch_flag(st_d.ctrl, c) && ch_en(st_d.ctrl, c)) begin
        st_d.vector = eirq_vector(c);
        found       = 1'b1;
      end
    end

    // Power state
    unique case (st_q.pstate)
      PS_RUN: begin
        if (standby_enter) st_d.pstate = PS_STANDBY;
      end
      PS_STANDBY: begin
        if (hold_release) st_d.pstate = PS_HALT;
      end
      PS_HALT: begin
        if (irq_accept) st_d.pstate = PS_RUN;
      end
      default: st_d.pstate = PS_RUN;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_q <= STATE_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < CH_N; g++) begin : g_req
      assign irq_request[g] = ch_flag(st_q.ctrl, g) & ch_en(st_q.ctrl, g);
    end
  endgenerate

  assign hold_release = |irq_request;
  assign vector_valid = |irq_request;
  assign vector_addr  = st_q.vector;
  assign rdata        = st_q.rdata;
  assign cpu_state    = st_q.pstate;
  assign irq          = |(st_q.evt_status & st_q.evt_mask);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  generate
    for (g = 0; g < CH_N; g++) begin : g_ast
      AST_OFF_NO_SET: assert property (
        ch_mode(st_q.ctrl, g) == MODE_OFF && !ch_flag(st_q.ctrl, g) && !wr_sel[g/2]
        |=> !ch_flag(st_q.ctrl, g))
        else $error("Flag set with detection off");

      AST_BOTH_EDGES: assert property (
        ch_mode(st_q.ctrl, g) == MODE_BOTH && (st_q.prev[g] != st_q.sync2[g])
        |=> ch_flag(st_q.ctrl, g))
        else $error("Both-edge mode missed an edge");

      AST_LEVEL: assert property (
        ch_mode(st_q.ctrl, g) == MODE_LEVEL && (st_q.sync2[g] ^ pin_invert[g]) == 1'b0
        |=> ch_flag(st_q.ctrl, g))
        else $error("Level mode missed an active level");

      AST_EDGE: assert property (
        ch_mode(st_q.ctrl, g) == MODE_EDGE && (st_q.prev[g] ^ pin_invert[g])
        && !(st_q.sync2[g] ^ pin_invert[g])
        |=> ch_flag(st_q.ctrl, g))
        else $error("Edge mode missed the selected edge");

      AST_PIN_TO_FLAG: assert property (
        (ch_mode(st_q.ctrl, g) == MODE_BOTH && $rose(ext_irq_pin[g]))
        ##1 (ch_mode(st_q.ctrl, g) == MODE_BOTH && ext_irq_pin[g]) [*2]
        |=> ch_flag(st_q.ctrl, g))
        else $error("Pin edge did not set flag three cycles later");

      AST_STICKY: assert property (
        ch_flag(st_q.ctrl, g) && !wr_sel[g/2] |=> ch_flag(st_q.ctrl, g))
        else $error("Flag cleared without a software write");

      AST_SET_WINS: assert property (
        trig[g] && wr_sel[g/2] && !bus.wdata[eirq_ch_lsb(g)+FLAG_BIT]
        |=> ch_flag(st_q.ctrl, g))
        else $error("Software clear beat a trigger");

      AST_REQUEST: assert property (
        ch_flag(st_q.ctrl, g) && ch_en(st_q.ctrl, g) |-> irq_request[g] && hold_release)
        else $error("Request or hold release missing");

      AST_VECTOR_ONLY: assert property (
        irq_request == (6'h01 << g) |-> vector_addr == eirq_vector(g))
        else $error("Wrong vector for single pending channel");
    end

    for (g = 0; g < REG_N; g++) begin : g_ast_reg
      AST_READBACK: assert property (
        rd_sel[g] |=> rdata == $past(st_q.ctrl[g]))
        else $error("Pair register read back wrong");
    end
  endgenerate

  AST_STANDBY_EXIT: assert property (
    cpu_state == PS_STANDBY && hold_release |=> cpu_state == PS_HALT ##0 cpu_state != PS_RUN)
    else $error("Hold release did not move standby to halt");

  AST_HALT_RUN: assert property (
    cpu_state == PS_HALT && irq_accept |=> cpu_state == PS_RUN)
    else $error("Accepted interrupt did not return to run");

  COV_LEVEL_SET: cover property (
    ch_mode(st_q.ctrl, 1) == MODE_LEVEL ##1 $rose(ch_flag(st_q.ctrl, 1)));
  COV_BOTH_SET: cover property (
    ch_mode(st_q.ctrl, 5) == MODE_BOTH ##1 $rose(ch_flag(st_q.ctrl, 5)));
  COV_WAKE: cover property (
    cpu_state == PS_STANDBY ##1 cpu_state == PS_HALT ##[1:20] cpu_state == PS_RUN);
  COV_IRQ: cover property ($rose(irq));

endmodule

// >>> tb/eirq_src.sv
// Model of the outside world driving the external interrupt pins.
// Assumes the bench sets the wanted pin levels; pins move a few ns after mclk.
`timescale 1ns/10ps
module eirq_src
  import eirq_pkg::*;
(
  input  wire logic            mclk,
  input  wire logic [CH_N-1:0] level,
  output logic      [CH_N-1:0] ext_irq_pin
);
  // Off-edge change, so sampling is asynchronous to the source
  always @(posedge mclk) ext_irq_pin <= #3 level;
endmodule

// >>> tb/tb.sv
// Self-checking bench for the channel 2 to 7 external interrupt detector.
// Assumes the pin source model and register access over the plain port.
`timescale 1ns/10ps
module tb
  import eirq_pkg::*;
;
  logic             mclk, reset, standby_enter, irq_accept, hold_release, vector_valid, irq;
  eirq_bus_req_type bus;
  logic [7:0]       rdata;
  logic [CH_N-1:0]  pins, lvl, pin_invert, irq_request;
  logic [15:0]      vector_addr;
  eirq_pstate_type  cpu_state;
  int               n_errors, checks;
  logic [15:0]      a;
  int               sh;
  logic [15:0] vec [6] = '{16'h8018, 16'h801c, 16'h8020, 16'h8024, 16'h8034, 16'h8038};
  logic [1:0]  md  [6] = '{2'h2, 2'h2, 2'h2, 2'h1, 2'h1, 2'h1};
  logic        inv [6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  logic        st  [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
  logic        en  [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
  logic        ex  [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};

  eirq_src src (.mclk(mclk), .level(lvl), .ext_irq_pin(pins));

  eirq_top dut (
    .mclk(mclk), .reset(reset), .bus(bus), .rdata(rdata), .ext_irq_pin(pins),
    .pin_invert(pin_invert), .standby_enter(standby_enter), .irq_accept(irq_accept),
    .irq_request(irq_request), .hold_release(hold_release), .vector_addr(vector_addr),
    .vector_valid(vector_valid), .cpu_state(cpu_state), .irq(irq)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic summarize;
    if (n_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h got %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] ad, input logic [7:0] d);
    @(posedge mclk) bus <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk) bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] ad, input logic [7:0] exp, input string nm);
    @(posedge mclk) bus <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk) bus.rd <= 1'b0;
    #1 chk(nm, 16'(exp), 16'(rdata));
  endtask

  task automatic settle;
    repeat (5) @(posedge mclk);
    #1;
  endtask

  task automatic pulse_cpu(input logic sb);
    @(posedge mclk) begin
      standby_enter <= sb;
      irq_accept    <= ~sb;
    end
    @(posedge mclk) {standby_enter, irq_accept} <= 2'b00;
    #1;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    bus = '0;
    lvl = '0;
    pin_invert = '0;
    standby_enter = 1'b0;
    irq_accept = 1'b0;
    n_errors = 0;
    checks = 0;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    for (int r = 0; r < 3; r++) begin
      a = ADDR_PAIR_2_3 + 16'(r);
      rd(a, 8'h00, "ctrl_reset");
      wr(a, 8'hdd);
      rd(a, 8'hdd, "ctrl_rw");
      wr(a, 8'h00);
    end
    wr(16'h7fd8, 8'hff);
    rd(16'h7fd8, 8'h00, "unmapped");
    // Event status, mask and irq line
    wr(ADDR_EVT_MASK, 8'h01);
    rd(ADDR_EVT_MASK, 8'h01, "evt_mask");
    wr(ADDR_PAIR_2_3, 8'h0c);
    @(posedge mclk) lvl[0] <= 1'b1;
    settle();
    chk("irq", 16'h1, 16'(irq));
    chk("irq_request", 16'h0, 16'(irq_request));
    chk("vector_valid", 16'h0, 16'(vector_valid));
    wr(ADDR_EVT_MASK, 8'h00);
    settle();
    chk("irq_masked", 16'h0, 16'(irq));
    wr(ADDR_EVT_MASK, 8'h01);
    settle();
    chk("irq", 16'h1, 16'(irq));
    rd(ADDR_EVT_STATUS, 8'h01, "evt_status");
    chk("irq_cleared", 16'h0, 16'(irq));
    wr(ADDR_EVT_STATUS, 8'hff);
    rd(ADDR_EVT_STATUS, 8'h00, "evt_status_ro");
    wr(ADDR_PAIR_2_3, 8'h00);
    // Each channel: both edges, request, vector, then mode off
    for (int c = 0; c < 6; c++) begin
      a = ADDR_PAIR_2_3 + 16'(c / 2);
      sh = (c % 2) * 4;
      wr(a, 8'h0d << sh);
      @(posedge mclk) lvl[c] <= ~lvl[c];
      settle();
      chk("irq_request", 16'(1 << c), 16'(irq_request));
      chk("vector_addr", vec[c], vector_addr);
      chk("hold_release", 16'h1, 16'(hold_release));
      chk("vector_valid", 16'h1, 16'(vector_valid));
      rd(a, 8'h0f << sh, "ctrl_hit");
      wr(a, 8'h00);
      @(posedge mclk) lvl[c] <= ~lvl[c];
      settle();
      rd(a, 8'h00, "ctrl_off");
    end
    // Level and single-edge modes with both polarities on channel 3
    for (int k = 0; k < 6; k++) begin
      @(posedge mclk) begin
        pin_invert[1] <= inv[k];
        lvl[1]        <= st[k];
      end
      wr(ADDR_PAIR_2_3, 8'h00);
      settle();
      wr(ADDR_PAIR_2_3, 8'({md[k], 2'b00}) << 4);
      settle();
      rd(ADDR_PAIR_2_3, 8'({md[k], 2'b00}) << 4, "mode_idle");
      @(posedge mclk) lvl[1] <= en[k];
      settle();
      rd(ADDR_PAIR_2_3, 8'({md[k], ex[k], 1'b0}) << 4, "mode_hit");
      wr(ADDR_PAIR_2_3, 8'({md[k], 2'b00}) << 4);
      settle();
      rd(ADDR_PAIR_2_3, 8'({md[k], ex[k] & (md[k] == 2'h1), 1'b0}) << 4, "cleared");
    end
    wr(ADDR_PAIR_2_3, 8'h00);
    // Standby, release to halt, accept back to run
    pulse_cpu(1'b1);
    chk("cpu_state", 16'(PS_STANDBY), 16'(cpu_state));
    pulse_cpu(1'b0);
    chk("cpu_state", 16'(PS_STANDBY), 16'(cpu_state));
    wr(ADDR_PAIR_4_5, 8'h03);
    settle();
    chk("cpu_state", 16'(PS_HALT), 16'(cpu_state));
    chk("vector_addr", 16'h8020, vector_addr);
    pulse_cpu(1'b0);
    chk("cpu_state", 16'(PS_RUN), 16'(cpu_state));
    wr(ADDR_PAIR_4_5, 8'h00);
    summarize();
  end

  // Cut a hang short
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    summarize();
  end
endmodule
